// >>> tws_pkg.sv
package tws_pkg;

  // Register byte addresses
  localparam logic [7:0] CTRL_OFS   = 8'hb8;
  localparam logic [7:0] DATA_OFS   = 8'hbc;
  localparam logic [7:0] STATUS_OFS = 8'hc0;
  localparam logic [7:0] PINS_OFS   = 8'hc4;

  // Control register fields
  localparam int CTRL_SIE   = 7;
  localparam int CTRL_OIE   = 6;
  localparam int CTRL_WM_HI = 5;
  localparam int CTRL_WM_LO = 4;
  localparam int CTRL_CS_HI = 3;
  localparam int CTRL_CS_LO = 2;
  localparam int CTRL_CLK   = 1;
  localparam int CTRL_TC    = 0;

  // Status register fields
  localparam int STAT_START = 7;
  localparam int STAT_WRAP  = 6;
  localparam int STAT_STOP  = 5;
  localparam int STAT_COLL  = 4;

  // Pin control register fields
  localparam int PIN_GIE      = 0;
  localparam int PIN_SDA_DIR  = 1;
  localparam int PIN_SCL_DIR  = 2;
  localparam int PIN_DO_DIR   = 3;
  localparam int PIN_SDA_PORT = 4;
  localparam int PIN_SCL_PORT = 5;

  // Reset values and the counter's top value
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [3:0] COUNT_RST = 4'h0;
  localparam logic [5:0] PINS_RST  = 6'h30;
  localparam logic [3:0] COUNT_MAX = 4'hf;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Wire modes
  typedef enum logic [1:0] {
    TWS_WM_OFF   = 2'b00,
    TWS_WM_THREE = 2'b01,
    TWS_WM_TWO   = 2'b10,
    TWS_WM_TWO_H = 2'b11
  } tws_wire_mode_t;

  // Control bits kept by software
  typedef struct packed {
    logic           start_irq_enable;
    logic           wrap_irq_enable;
    tws_wire_mode_t wire_mode_select;
    logic [1:0]     shift_clock_source;
    logic           soft_clock_strobe;
  } tws_ctrl_t;

  // Pin control bits
  typedef struct packed {
    logic scl_port;
    logic sda_port;
    logic do_dir;
    logic scl_dir;
    logic sda_dir;
    logic global_irq_enable;
  } tws_pins_t;

  // Whole state of the block
  typedef struct packed {
    tws_ctrl_t  ctrl;
    tws_pins_t  pins;
    logic [7:0] shift;
    logic       out_latch;
    logic [3:0] bit_edge_count;
    logic       start_seen_flag;
    logic       count_wrap_flag;
    logic       stop_seen_flag;
    logic       start_hold;
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_d;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_d;
    logic       aw_have;
    logic [7:0] aw_addr;
    logic       w_have;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } tws_state_t;

endpackage

// >>> tws_shift_unit.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
// How it works
// - Two-wire mode: start condition on the bus sets the start flag.
// - Other modes: every counter increment sets the start flag.
// - Start flag clears on write of one; clearing releases the start clock hold.
// - Start interrupt request while flag, its enable and global enable are set.
// - Counter wrap from 15 to 0 sets the wrap flag.
// - Wrap interrupt request while flag, its enable and global enable are set.
// - Wrap flag clears on write of one; clearing releases the wrap clock hold.
// - Two-wire stop condition sets stop flag, write one clears, no interrupt.
// - Collision bit reads one when shift bit 7 differs from data pin.
// - Counter readable and writable in status low bits, counts selected clock.
// - External clock source: both clock edges increment the counter.
// - External source with soft clock bit set: toggle strobe clocks the counter.
// - Shift register accessed directly; a software write beats a shift.
// - Shift register moves left; bit 7 drives data output through a latch.
// - Latch open in first half cycle for external clock, always otherwise.
// - Wire mode changes outputs and start/stop detection; inputs always clock and feed data.
// - Start detector works only in two-wire mode and can wake from any sleep.
// - Wrap interrupt wakes the processor from idle sleep only.
// - After a start, clock held low from next falling edge until flag cleared.
// - Serial data sampled into the shift register on rising clock edges for source 10, falling for 11.
// - Counter may be preloaded to 14 so it wraps again after acknowledge.
// - Mode 00 off, 01 three-wire, 10 two-wire, 11 two-wire with wrap hold.
// - Two-wire data pin pulled low when latched bit 7 or port bit is zero.
module tws_shift_unit (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire logic       timer_match,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            do_out,
  output logic            do_oe,
  output logic            start_irq,
  output logic            wrap_irq,
  output logic            wake_any_sleep,
  output logic            wake_idle_sleep
);

  tws_pkg::tws_state_t st_r;
  tws_pkg::tws_state_t st_nxt;

  // Two-wire modes share the upper mode bit
  function automatic logic is_two_wire(input tws_pkg::tws_wire_mode_t m);
    is_two_wire = (m == tws_pkg::TWS_WM_TWO) || (m == tws_pkg::TWS_WM_TWO_H);
  endfunction

  // Decoding shared by the read path and the write path
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    case (a)
      tws_pkg::CTRL_OFS:   reg_sel = 2'h0;
      tws_pkg::DATA_OFS:   reg_sel = 2'h1;
      tws_pkg::STATUS_OFS: reg_sel = 2'h2;
      default:             reg_sel = 2'h3;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == tws_pkg::CTRL_OFS) || (a == tws_pkg::DATA_OFS) ||
              (a == tws_pkg::STATUS_OFS) || (a == tws_pkg::PINS_OFS);
  endfunction

  logic       two_wire;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       ext_src;
  logic       wr_go;
  logic       wr_ctrl;
  logic       wr_data;
  logic       wr_stat;
  logic       wr_pins;
  logic       soft_strobe;
  logic       toggle_strobe;
  logic       shift_pulse;
  logic       count_pulse;
  logic       wrap_event;
  logic       latch_open;
  logic       collision;
  logic       wrap_hold;
  logic [7:0] status_val;
  logic [1:0] cs_eff;
  logic       soft_sel;

  // Edge and condition detection on the synchronised pins
  assign two_wire   = is_two_wire(st_r.ctrl.wire_mode_select);
  assign scl_rise   = st_r.scl_s2 & ~st_r.scl_d;
  assign scl_fall   = ~st_r.scl_s2 & st_r.scl_d;
  // Data edge while clock stays high; start falls, stop rises
  assign start_cond = two_wire & st_r.scl_s2 & st_r.scl_d
                      & st_r.sda_d & ~st_r.sda_s2;
  assign stop_cond  = two_wire & st_r.scl_s2 & st_r.scl_d
                      & ~st_r.sda_d & st_r.sda_s2;
  assign ext_src    = st_r.ctrl.shift_clock_source[1];

  // A write is carried out once address and data have both arrived and byte lane 0 is strobed
  assign wr_go   = st_r.aw_have & st_r.w_have & ~st_r.bvalid & st_r.w_lane0;
  assign wr_ctrl = wr_go & (reg_sel(st_r.aw_addr) == 2'h0);
  assign wr_data = wr_go & (reg_sel(st_r.aw_addr) == 2'h1);
  assign wr_stat = wr_go & (reg_sel(st_r.aw_addr) == 2'h2);
  assign wr_pins = wr_go & (st_r.aw_addr == tws_pkg::PINS_OFS);

  // Strobes exist only in the cycle of the control write
  assign soft_strobe   = wr_ctrl & st_r.w_data[tws_pkg::CTRL_CLK];
  assign toggle_strobe = wr_ctrl & st_r.w_data[tws_pkg::CTRL_TC];

  // A control write strobes with the source it writes, so one write both selects and clocks
  assign cs_eff   = wr_ctrl ? st_r.w_data[tws_pkg::CTRL_CS_HI:tws_pkg::CTRL_CS_LO]
                            : st_r.ctrl.shift_clock_source;
  assign soft_sel = wr_ctrl ? st_r.w_data[tws_pkg::CTRL_CLK] : st_r.ctrl.soft_clock_strobe;

  // Clock source selection for shift register and counter
  always_comb begin
    shift_pulse = 1'b0;
    count_pulse = 1'b0;
    case (cs_eff)
      2'b00: begin
        shift_pulse = soft_strobe;
        count_pulse = soft_strobe;
      end
      2'b01: begin
        shift_pulse = timer_match;
        count_pulse = timer_match;
      end
      2'b10: begin
        shift_pulse = scl_rise;
        // Written soft clock bit hands the counter to the toggle strobe
        count_pulse = soft_sel ? toggle_strobe : (scl_rise | scl_fall);
      end
      2'b11: begin
        shift_pulse = scl_fall;
        count_pulse = soft_sel ? toggle_strobe : (scl_rise | scl_fall);
      end
      default: begin
        shift_pulse = 1'b0;
        count_pulse = 1'b0;
      end
    endcase
  end

  assign wrap_event = count_pulse & (st_r.bit_edge_count == tws_pkg::COUNT_MAX);

  // Latch closes in the sampling half so output moves on the opposite edge
  assign latch_open = ~ext_src |
                      (st_r.ctrl.shift_clock_source[0] ? st_r.scl_s2 : ~st_r.scl_s2);

  assign collision = st_r.shift[7] ^ st_r.sda_s2;
  assign wrap_hold = (st_r.ctrl.wire_mode_select == tws_pkg::TWS_WM_TWO_H)
                     & st_r.count_wrap_flag;

  assign status_val = {st_r.start_seen_flag, st_r.count_wrap_flag, st_r.stop_seen_flag,
                       collision, st_r.bit_edge_count};

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;

    // Pin synchronisers; inputs are sampled in every wire mode
    st_nxt.scl_s1 = scl_in;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.scl_d  = st_r.scl_s2;
    st_nxt.sda_s1 = sda_in;
    st_nxt.sda_s2 = st_r.sda_s1;
    st_nxt.sda_d  = st_r.sda_s2;

    // Bus: address and data accepted in either order
    if (s_axi_awvalid && !st_r.aw_have) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_have) begin
      st_nxt.w_have  = 1'b1;
      st_nxt.w_data  = s_axi_wdata[7:0];
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = addr_ok(st_r.aw_addr) ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = addr_ok(s_axi_araddr) ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
      case (reg_sel(s_axi_araddr))
        2'h0: st_nxt.rdata = {st_r.ctrl.start_irq_enable, st_r.ctrl.wrap_irq_enable,
                              st_r.ctrl.wire_mode_select, st_r.ctrl.shift_clock_source,
                              2'b00};
        2'h1: st_nxt.rdata = st_r.shift;
        2'h2: st_nxt.rdata = status_val;
        default: st_nxt.rdata = (s_axi_araddr == tws_pkg::PINS_OFS) ?
                                {2'b00, st_r.pins} : 8'h00;
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Control and pin registers
    if (wr_ctrl) begin
      st_nxt.ctrl.start_irq_enable   = st_r.w_data[tws_pkg::CTRL_SIE];
      st_nxt.ctrl.wrap_irq_enable    = st_r.w_data[tws_pkg::CTRL_OIE];
      st_nxt.ctrl.wire_mode_select   =
        tws_pkg::tws_wire_mode_t'(st_r.w_data[tws_pkg::CTRL_WM_HI:tws_pkg::CTRL_WM_LO]);
      st_nxt.ctrl.shift_clock_source = st_r.w_data[tws_pkg::CTRL_CS_HI:tws_pkg::CTRL_CS_LO];
      st_nxt.ctrl.soft_clock_strobe  = st_r.w_data[tws_pkg::CTRL_CLK];
    end
    if (wr_pins) begin
      st_nxt.pins = st_r.w_data[5:0];
    end
    // Toggle strobe flips the clock port bit so a master can make edges
    if (toggle_strobe) begin
      st_nxt.pins.scl_port = ~st_nxt.pins.scl_port;
    end

    // Shift register: software write wins over a coincident shift
    if (wr_data) begin
      st_nxt.shift = st_r.w_data;
    end else if (shift_pulse) begin
      st_nxt.shift = {st_r.shift[6:0], st_r.sda_s2};
    end
    if (latch_open) begin
      st_nxt.out_latch = st_nxt.shift[7];
    end

    // Counter: a software load beats an increment; used to preload 14
    if (wr_stat) begin
      st_nxt.bit_edge_count = st_r.w_data[3:0];
    end else if (count_pulse) begin
      st_nxt.bit_edge_count = st_r.bit_edge_count + 4'h1;
    end

    // Flags: write one clears, a new event in the same cycle still sets
    if (wr_stat && st_r.w_data[tws_pkg::STAT_START]) begin
      st_nxt.start_seen_flag = 1'b0;
    end
    if (wr_stat && st_r.w_data[tws_pkg::STAT_WRAP]) begin
      st_nxt.count_wrap_flag = 1'b0;
    end
    if (wr_stat && st_r.w_data[tws_pkg::STAT_STOP]) begin
      st_nxt.stop_seen_flag = 1'b0;
    end
    if (two_wire ? start_cond : count_pulse) begin
      st_nxt.start_seen_flag = 1'b1;
    end
    if (wrap_event) begin
      st_nxt.count_wrap_flag = 1'b1;
    end
    if (stop_cond) begin
      st_nxt.stop_seen_flag = 1'b1;
    end

    // Start hold arms on the first falling clock edge after a start
    if (!st_nxt.start_seen_flag || !two_wire) begin
      st_nxt.start_hold = 1'b0;
    end else if (scl_fall) begin
      st_nxt.start_hold = 1'b1;
    end
  end

  // State register; a synchronous reset clears control, flags and counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r                <= '0;
      st_r.ctrl           <= tws_pkg::tws_ctrl_t'(tws_pkg::CTRL_RST[7:1]);
      st_r.pins           <= tws_pkg::PINS_RST;
      st_r.shift          <= tws_pkg::DATA_RST;
      st_r.bit_edge_count <= tws_pkg::COUNT_RST;
      st_r.scl_s1         <= 1'b1;
      st_r.scl_s2         <= 1'b1;
      st_r.scl_d          <= 1'b1;
      st_r.sda_s1         <= 1'b1;
      st_r.sda_s2         <= 1'b1;
      st_r.sda_d          <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus handshakes
  assign s_axi_awready = ~st_r.aw_have;
  assign s_axi_wready  = ~st_r.w_have;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rresp   = st_r.rresp;
  assign s_axi_rdata   = {24'h000000, st_r.rdata};

  // Pin drivers per wire mode; two-wire pins are open drain
  always_comb begin
    do_out  = st_r.out_latch;
    do_oe   = st_r.pins.do_dir & (st_r.ctrl.wire_mode_select == tws_pkg::TWS_WM_THREE);
    sda_out = st_r.pins.sda_port;
    sda_oe  = st_r.pins.sda_dir;
    scl_out = st_r.pins.scl_port;
    scl_oe  = st_r.pins.scl_dir;
    if (two_wire) begin
      sda_out = 1'b0;
      sda_oe  = st_r.pins.sda_dir & (~st_r.out_latch | ~st_r.pins.sda_port);
      scl_out = 1'b0;
      scl_oe  = st_r.pins.scl_dir &
                (~st_r.pins.scl_port | st_r.start_hold | wrap_hold);
    end
  end

  // Interrupt requests and wake requests
  assign start_irq       = st_r.start_seen_flag & st_r.ctrl.start_irq_enable
                           & st_r.pins.global_irq_enable;
  assign wrap_irq        = st_r.count_wrap_flag & st_r.ctrl.wrap_irq_enable
                           & st_r.pins.global_irq_enable;
  assign wake_any_sleep  = start_irq & two_wire;
  assign wake_idle_sleep = wrap_irq;

endmodule

// >>> tws_shift_unit_assertions.sv
`timescale 1ns/100ps
// Watches bus answers and request outputs at the unit's ports
module tws_shift_unit_assertions (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic        start_irq,
  input logic        wrap_irq,
  input logic        wake_any_sleep,
  input logic        wake_idle_sleep
);
  // Steps of a register access
  sequence s_w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // Bus answers come within the promised cycles and leave only on ready
  AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ar_taken |=> s_axi_rvalid) else $error("read answer late");
  AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_w_taken |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  AST_BVALID_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_axi_bvalid) |-> $past(s_axi_bready)) else $error("bvalid dropped early");
  AST_RVALID_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_axi_rvalid) |-> $past(s_axi_rready)) else $error("rvalid dropped early");
  AST_RDATA_NARROW: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  // Requests only drop through a software write
  AST_START_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(start_irq) |-> s_axi_bvalid) else $error("start request lost");
  AST_WRAP_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(wrap_irq) |-> s_axi_bvalid) else $error("wrap request lost");
  // Wake requests follow the interrupt requests
  AST_WAKE_ANY: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_any_sleep |-> start_irq) else $error("wake without start request");
  AST_WAKE_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_idle_sleep == wrap_irq) else $error("idle wake mismatch");
  AST_RESET_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> !(start_irq || wrap_irq)) else $error("request after reset");
endmodule

bind tws_shift_unit tws_shift_unit_assertions u_tws_shift_unit_assertions (.*);

// >>> tws_mst.sv
`timescale 1ns/100ps
// Far-side bus master; both lines have pull-ups, so released means high
module tws_mst (
  input  wire logic aclk,
  input  wire logic scl_line,
  output logic      m_scl,
  output logic      m_sda
);
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  // Half of the 200 ns link period
  task automatic half();
    repeat (4) @(posedge aclk);
  endtask
  task automatic rel();
    @(posedge aclk) m_scl <= 1'b1;
  endtask
  // The slave may stretch the clock, so wait until the line is high
  task automatic wait_high(output bit ok);
    int n;
    n = 0;
    while (scl_line !== 1'b1 && n < 64) begin
      @(posedge aclk);
      n++;
    end
    ok = (scl_line === 1'b1);
  endtask
  task automatic up();
    bit ok;
    rel();
    wait_high(ok);
  endtask
  task automatic fall();
    @(posedge aclk) m_scl <= 1'b0;
    half();
  endtask
  task automatic setd(input logic b);
    @(posedge aclk) m_sda <= b;
  endtask
  // Data changes only while the clock is low
  task automatic bitx(input logic b);
    setd(b);
    half();
    up();
    half();
    fall();
  endtask
  task automatic start();
    setd(1'b0);
    half();
  endtask
  task automatic stop();
    setd(1'b0);
    half();
    up();
    half();
    setd(1'b1);
    half();
  endtask
endmodule

// >>> tws_shift_unit_test.sv
`timescale 1ns/100ps
// Self-checking bench for the serial shift unit
module tws_shift_unit_test;
  localparam logic [7:0] A_CT = tws_pkg::CTRL_OFS;
  localparam logic [7:0] A_DT = tws_pkg::DATA_OFS;
  localparam logic [7:0] A_ST = tws_pkg::STATUS_OFS;
  localparam logic [7:0] A_PN = tws_pkg::PINS_OFS;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, timer_match, scl_out, scl_oe;
  logic        sda_out, sda_oe, do_out, do_oe, start_irq, wrap_irq;
  logic        wake_any_sleep, wake_idle_sleep;
  wire         scl_in, sda_in, m_scl, m_sda;
  int          err_count, samples_checked, cycles;

  // Open-drain lines: low if any party pulls low
  assign scl_in = m_scl & (scl_oe ? scl_out : 1'b1);
  assign sda_in = m_sda & (sda_oe ? sda_out : 1'b1);

  tws_shift_unit u_tws_shift_unit (.*);
  tws_mst u_tws_mst (.aclk(aclk), .scl_line(scl_in), .m_scl(m_scl), .m_sda(m_sda));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic logic [7:0] b8(input logic x);
    return {7'h0, x};
  endfunction
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er = tws_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {6'h0, er}, {6'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, m, e);
    logic [7:0] v;
    logic [1:0] r;
    rd(a, v, r);
    chk(nm, e, v & m);
    chk("rresp", {6'h0, tws_pkg::RESP_OKAY}, {6'h0, r});
  endtask

  // Reset values, an unmapped place and the collision bit
  task automatic t_reset();
    logic [7:0] v;
    logic [1:0] r;
    rc("ctrl", A_CT, 8'hff, tws_pkg::CTRL_RST);
    rc("pins", A_PN, 8'hff, {2'h0, tws_pkg::PINS_RST});
    rc("data", A_DT, 8'hff, tws_pkg::DATA_RST);
    rc("status", A_ST, 8'hff, 8'h10);
    rd(8'hf0, v, r);
    chk("unmapped rresp", {6'h0, tws_pkg::RESP_SLVERR}, {6'h0, r});
    wr(8'hf0, 8'h5a, tws_pkg::RESP_SLVERR);
    wr(A_DT, 8'h80);
    rc("data", A_DT, 8'hff, 8'h80);
    rc("collision", A_ST, 8'h10, 8'h00);
    $display("t_reset done");
  endtask
  // Counting from pin edges, toggle strobe and soft strobe outside two-wire
  task automatic t_soft();
    wr(A_PN, 8'h31);
    wr(A_CT, 8'h08);
    wr(A_ST, 8'he0);
    u_tws_mst.fall();
    u_tws_mst.up();
    u_tws_mst.half();
    rc("edge count", A_ST, 8'hef, 8'h82);
    wr(A_CT, 8'h0b);
    rc("ctrl strobes", A_CT, 8'hff, 8'h08);
    rc("toggle count", A_ST, 8'h0f, 8'h03);
    wr(A_ST, 8'h8f);
    rc("count load", A_ST, 8'h8f, 8'h0f);
    wr(A_CT, 8'h12);
    rc("soft wrap", A_ST, 8'hcf, 8'hc0);
    chk("wrap masked", 8'h00, b8(wrap_irq));
    wr(A_CT, 8'h40);
    chk("wrap pending", 8'h01, b8(wrap_irq));
    wr(A_ST, 8'hc0);
    chk("wrap cleared", 8'h00, b8(wrap_irq));
    $display("t_soft done");
  endtask
  // Start condition, clock hold and its release by software
  task automatic t_start();
    bit ok;
    wr(A_PN, 8'h35);
    wr(A_CT, 8'hf8);
    wr(A_ST, 8'he0);
    u_tws_mst.start();
    u_tws_mst.half();
    chk("start irq", 8'h01, b8(start_irq));
    chk("wake any", 8'h01, b8(wake_any_sleep));
    u_tws_mst.fall();
    u_tws_mst.half();
    chk("scl hold", 8'h01, b8(scl_oe));
    u_tws_mst.setd(1'b1);
    u_tws_mst.rel();
    u_tws_mst.half();
    chk("scl stretched", 8'h00, b8(scl_in));
    wr(A_ST, 8'h80);
    u_tws_mst.wait_high(ok);
    chk("scl released", 8'h01, b8(ok));
    chk("start cleared", 8'h00, b8(start_irq));
    $display("t_start done");
  endtask
  // Rest of the address byte, acknowledge preload and stop
  task automatic t_byte();
    logic [7:0] b;
    b = 8'ha5;
    u_tws_mst.half();
    u_tws_mst.fall();
    for (int i = 6; i >= 0; i--) u_tws_mst.bitx(b[i]);
    u_tws_mst.half();
    chk("wrap irq", 8'h01, b8(wrap_irq));
    chk("wake idle", 8'h01, b8(wake_idle_sleep));
    chk("wrap hold", 8'h01, b8(scl_oe));
    rc("data", A_DT, 8'hff, b);
    rc("status", A_ST, 8'hef, 8'h40);
    wr(A_ST, 8'h4e);
    chk("wrap released", 8'h00, b8(scl_oe));
    u_tws_mst.bitx(1'b0);
    rc("ack wrap", A_ST, 8'hcf, 8'h40);
    wr(A_ST, 8'h40);
    u_tws_mst.stop();
    rc("stop", A_ST, 8'he0, 8'h20);
    chk("stop irq", 8'h00, {6'h0, start_irq, wrap_irq});
    wr(A_ST, 8'h20);
    rc("stop clear", A_ST, 8'he0, 8'h00);
    $display("t_byte done");
  endtask

  // Cuts a hang short; the tests need a few hundred cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, timer_match} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_soft();
    t_start();
    t_byte();
    complete_run();
  end
endmodule
